// ==== src/bsr_pkg.sv ====
// Purpose: shared constants and carriers for the bridge status readback block
// Assumes: one byte command interface from the host-side serial slave
// Notes: command codes not fixed by the device description are chosen here
package bsr_pkg;
  // function command codes
  localparam logic [7:0] CMD_DEV_RESET = 8'hf0;
  localparam logic [7:0] CMD_SET_PTR = 8'he1;
  localparam logic [7:0] CMD_WR_CFG = 8'hd2;
  localparam logic [7:0] CMD_ADJ_PORT = 8'hc3;
  localparam logic [7:0] CMD_LINE_RESET = 8'hb4;
  localparam logic [7:0] CMD_SINGLE_BIT = 8'h87;
  localparam logic [7:0] CMD_WRITE_BYTE = 8'ha5;
  localparam logic [7:0] CMD_READ_BYTE = 8'h96;
  localparam logic [7:0] CMD_TRIPLET = 8'h78;
  // read pointer codes
  localparam logic [7:0] PTR_STATUS = 8'hf0;
  localparam logic [7:0] PTR_RDATA = 8'he1;
  localparam logic [7:0] PTR_CFG = 8'hc3;
  localparam logic [7:0] PTR_PORT = 8'hb4;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_PPD = 1;
  localparam int ST_SD = 2;
  localparam int ST_LL = 3;
  localparam int ST_RST = 4;
  localparam int ST_SBR = 5;
  localparam int ST_TSB = 6;
  localparam int ST_DIR = 7;
  // adjust-port parameter byte layout: [7:5] selector, [4] overdrive, [3:0] code
  localparam int ADJ_SEL_LSB = 5;
  localparam int ADJ_OD_BIT = 4;
  localparam logic [2:0] ADJ_SEL_MAX = 3'h4;
  // port readback: eight slots per pass, last slot index
  localparam int PORT_SLOTS = 8;
  localparam logic [2:0] PORT_LAST = 3'h7;
  localparam logic [3:0] PORT_CODE_RST = 4'h6;
  localparam logic [7:0] PTR_RST = PTR_STATUS;

  // kind of line operation in flight
  typedef enum logic [1:0] {
    OP_OTHER = 2'b00,
    OP_RESET = 2'b01,
    OP_SBIT = 2'b10,
    OP_TRIP = 2'b11
  } bsr_op_t;

  // command from the serial slave
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] param;
    logic has_param;
  } bsr_cmd_t;

  // results captured in the link domain
  typedef struct packed {
    logic sd;
    logic presence_found;
    logic single_bit_result;
    logic triplet_second_result;
    logic dir;
  } bsr_res_t;
endpackage

// ==== src/bsr_status_readback.sv ====
// Purpose: status register, port readback and read pointer of the bridge
// Assumes: command and read strobes come from logic on core_clk
// Notes: line results are captured on link_clk and cross by toggle handshake
`timescale 1ns/10ps
`default_nettype none

module bsr_status_readback
  import bsr_pkg::*;
(
  // core clock and control
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // commands from the serial slave
  input wire logic cmd_valid,
  input wire bsr_cmd_t cmd,
  output logic cmd_ack_ff,
  output logic cmd_nack_ff,
  // host read side
  input wire logic rd_addr_strobe,
  input wire logic rd_byte_strobe,
  input wire logic [7:0] ext_rdata,
  input wire logic [7:0] ext_cfg,
  output logic [7:0] rd_data_ff,
  // start of a line operation toward the waveform generator
  output logic ow_start_ff,
  output logic [7:0] ow_cmd_ff,
  output logic [7:0] ow_param_ff,
  // line pin, asynchronous to both clocks
  input wire logic io_in,
  // link domain
  input wire logic link_clk,
  input wire logic lk_sample_short,
  input wire logic lk_sample_presence,
  input wire logic lk_sample_read,
  input wire logic lk_dir,
  input wire logic lk_op_done
);

  // maps selector and speed to a readback slot
  function automatic logic [2:0] port_slot(input logic [2:0] sel, input logic od);
    logic [3:0] s;
    s = 4'h0;
    if (sel < 3'h3) begin
      s = {sel, od};
    end else begin
      s = {1'b0, sel} + 4'h3;
    end
    return s[2:0];
  endfunction

  // true when a command may be accepted
  function automatic logic cmd_ok(input bsr_cmd_t c, input logic busy);
    logic ok;
    ok = 1'b0;
    unique case (c.code)
      CMD_DEV_RESET: ok = 1'b1;
      CMD_SET_PTR: ok = c.has_param && (c.param == PTR_STATUS || c.param == PTR_RDATA ||
                        c.param == PTR_CFG || c.param == PTR_PORT);
      CMD_WR_CFG: ok = !busy && c.has_param && (c.param[7:4] == ~c.param[3:0]);
      CMD_ADJ_PORT: ok = !busy && c.has_param && (c.param[7:ADJ_SEL_LSB] <= ADJ_SEL_MAX);
      CMD_LINE_RESET, CMD_READ_BYTE: ok = !busy;
      CMD_SINGLE_BIT, CMD_WRITE_BYTE, CMD_TRIPLET: ok = !busy && c.has_param;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // line-kind commands that occupy the bus
  function automatic logic is_line(input logic [7:0] code);
    return code == CMD_LINE_RESET || code == CMD_SINGLE_BIT || code == CMD_WRITE_BYTE ||
           code == CMD_READ_BYTE || code == CMD_TRIPLET;
  endfunction

  // core-side synchronisers
  logic io_s1_ff, io_s2_ff; // line level, two stages
  logic tg_s1_ff, tg_s2_ff, tg_s3_ff; // done toggle, third stage for edge
  // link-side state
  logic lk_rst_s1_ff, lk_rst_s2_ff; // reset brought into link domain
  logic lk_line_s1_ff, lk_line_s2_ff; // line sampled in link domain
  logic lk_bit_ff; // second read sample of a triplet pending
  logic lk_tog_ff; // flips once per finished operation
  bsr_res_t lk_res_ff; // results held stable until the next operation
  // status bits
  logic busy_ff, ppd_ff, sd_ff, ll_ff, rst_flag_ff, sbr_ff, tsb_ff, dir_ff;
  logic [7:0] ptr_ff; // read pointer code
  logic [2:0] pidx_ff; // port readback slot
  logic [3:0] port_mem [PORT_SLOTS]; // parameter codes per slot
  bsr_op_t op_ff; // kind of line operation in flight
  // decode helpers
  logic accept, refuse, done_evt, dev_rst, line_go;
  logic [7:0] status_byte;

  assign accept = ce && cmd_valid && cmd_ok(cmd, busy_ff);
  assign refuse = ce && cmd_valid && !cmd_ok(cmd, busy_ff);
  assign dev_rst = accept && cmd.code == CMD_DEV_RESET;
  assign line_go = accept && is_line(cmd.code);
  assign done_evt = tg_s2_ff ^ tg_s3_ff;
  assign status_byte = {dir_ff, tsb_ff, sbr_ff, rst_flag_ff, ll_ff, sd_ff, ppd_ff, busy_ff};

  // link reset: the async-to-link path goes through two stages
  always_ff @(posedge link_clk) begin
    lk_rst_s1_ff <= rst;
    lk_rst_s2_ff <= lk_rst_s1_ff;
  end

  // line level into link domain
  always_ff @(posedge link_clk) begin
    lk_line_s1_ff <= io_in;
    lk_line_s2_ff <= lk_line_s1_ff;
  end

  // result capture at the sample strobes of the waveform generator
  always_ff @(posedge link_clk) begin
    if (lk_rst_s2_ff) begin
      lk_res_ff <= '0;
      lk_bit_ff <= 1'b0;
      lk_tog_ff <= 1'b0;
    end else begin
      if (lk_sample_short) begin
        lk_res_ff.sd <= !lk_line_s2_ff;
      end
      if (lk_sample_presence) begin
        lk_res_ff.presence_found <= !lk_line_s2_ff;
      end
      if (lk_sample_read) begin
        // first sample is the single bit, second the triplet's second bit
        if (!lk_bit_ff) begin
          lk_res_ff.single_bit_result <= lk_line_s2_ff;
        end else begin
          lk_res_ff.triplet_second_result <= lk_line_s2_ff;
        end
        lk_bit_ff <= 1'b1;
      end
      if (lk_op_done) begin
        lk_res_ff.dir <= lk_dir;
        lk_bit_ff <= 1'b0;
        lk_tog_ff <= !lk_tog_ff;
      end
    end
  end

  // core synchronisers; results are read only after the toggle settles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      io_s1_ff <= 1'b0;
      io_s2_ff <= 1'b0;
      tg_s1_ff <= 1'b0;
      tg_s2_ff <= 1'b0;
      tg_s3_ff <= 1'b0;
    end else if (ce) begin
      io_s1_ff <= io_in;
      io_s2_ff <= io_s1_ff;
      tg_s1_ff <= lk_tog_ff;
      tg_s2_ff <= tg_s1_ff;
      tg_s3_ff <= tg_s2_ff;
    end
  end

  // acknowledge or refuse each command byte string
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_ack_ff <= 1'b0;
      cmd_nack_ff <= 1'b0;
    end else if (ce) begin
      cmd_ack_ff <= accept;
      cmd_nack_ff <= refuse;
    end
  end

  // start pulse and command toward the waveform generator
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ow_start_ff <= 1'b0;
      ow_cmd_ff <= 8'h00;
      ow_param_ff <= 8'h00;
    end else if (ce) begin
      ow_start_ff <= line_go;
      if (line_go) begin
        ow_cmd_ff <= cmd.code;
        ow_param_ff <= cmd.param;
      end
    end
  end

  // read pointer and port readback slot
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_ff <= PTR_RST;
      pidx_ff <= 3'h0;
    end else if (ce) begin
      if (dev_rst || line_go) begin
        ptr_ff <= PTR_STATUS;
      end else if (accept && cmd.code == CMD_ADJ_PORT) begin
        ptr_ff <= PTR_PORT;
        pidx_ff <= 3'h0;
      end else if (accept && cmd.code == CMD_SET_PTR) begin
        ptr_ff <= cmd.param;
        pidx_ff <= 3'h0;
      end else if (rd_byte_strobe && ptr_ff == PTR_PORT) begin
        // wrap after the last slot back to the first
        pidx_ff <= (pidx_ff == PORT_LAST) ? 3'h0 : pidx_ff + 3'h1;
      end
    end
  end

  // parameter codes; device reset restores defaults
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < PORT_SLOTS; i++) begin
        port_mem[i] <= PORT_CODE_RST;
      end
    end else if (ce) begin
      if (dev_rst) begin
        for (int i = 0; i < PORT_SLOTS; i++) begin
          port_mem[i] <= PORT_CODE_RST;
        end
      end else if (accept && cmd.code == CMD_ADJ_PORT) begin
        port_mem[port_slot(cmd.param[7:ADJ_SEL_LSB], cmd.param[ADJ_OD_BIT])] <= cmd.param[3:0];
      end
    end
  end

  // busy flag and operation kind
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
      op_ff <= OP_OTHER;
    end else if (ce) begin
      if (dev_rst) begin
        busy_ff <= 1'b0;
        op_ff <= OP_OTHER;
      end else if (line_go) begin
        busy_ff <= 1'b1;
        unique case (cmd.code)
          CMD_LINE_RESET: op_ff <= OP_RESET;
          CMD_SINGLE_BIT: op_ff <= OP_SBIT;
          CMD_TRIPLET: op_ff <= OP_TRIP;
          default: op_ff <= OP_OTHER;
        endcase
      end else if (done_evt) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // result bits: only the finishing command's own fields change
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ppd_ff <= 1'b0;
      sd_ff <= 1'b0;
      sbr_ff <= 1'b0;
      tsb_ff <= 1'b0;
      dir_ff <= 1'b0;
    end else if (ce) begin
      if (dev_rst) begin
        ppd_ff <= 1'b0;
        sd_ff <= 1'b0;
        sbr_ff <= 1'b0;
        tsb_ff <= 1'b0;
        dir_ff <= 1'b0;
      end else if (done_evt && busy_ff) begin
        unique case (op_ff)
          OP_RESET: begin
            sd_ff <= lk_res_ff.sd;
            ppd_ff <= lk_res_ff.presence_found && !lk_res_ff.sd;
          end
          OP_SBIT: sbr_ff <= lk_res_ff.single_bit_result;
          OP_TRIP: begin
            sbr_ff <= lk_res_ff.single_bit_result;
            tsb_ff <= lk_res_ff.triplet_second_result;
            dir_ff <= lk_res_ff.dir;
          end
          OP_OTHER: sbr_ff <= sbr_ff;
        endcase
      end
    end
  end

  // reset flag and live level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rst_flag_ff <= 1'b1;
      ll_ff <= 1'b0;
    end else if (ce) begin
      if (dev_rst) begin
        rst_flag_ff <= 1'b1;
      end else if (accept && cmd.code == CMD_WR_CFG) begin
        rst_flag_ff <= 1'b0;
      end
      // sampled only at read addressing, no line activity started
      if (rd_addr_strobe && ptr_ff == PTR_STATUS) begin
        ll_ff <= io_s2_ff;
      end
    end
  end

  // read data mux, upper nibble of port bytes forced low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data_ff <= 8'h00;
    end else if (ce && rd_byte_strobe) begin
      unique case (ptr_ff)
        PTR_STATUS: rd_data_ff <= status_byte;
        PTR_PORT: rd_data_ff <= {4'h0, port_mem[pidx_ff]};
        PTR_CFG: rd_data_ff <= {4'h0, ext_cfg[3:0]};
        default: rd_data_ff <= ext_rdata;
      endcase
    end
  end

  // never presence with a short
  a_no_ppd_short: assert property (@(posedge core_clk) disable iff (rst) !(sd_ff && ppd_ff))
    else $error("presence reported during short");

  // line command raises busy next cycle
  a_busy_rise: assert property (@(posedge core_clk) disable iff (rst) line_go && !dev_rst |=> busy_ff)
    else $error("busy not raised by line command");

  // busy drops after done when no new start
  a_busy_fall: assert property (@(posedge core_clk) disable iff (rst)
    ce && done_evt && !line_go && !dev_rst |=> !busy_ff)
    else $error("busy not cleared at completion");

  // device reset result
  a_devrst_clear: assert property (@(posedge core_clk) disable iff (rst)
    dev_rst |=> rst_flag_ff && !busy_ff && !ppd_ff && !sd_ff && !sbr_ff && !tsb_ff && !dir_ff
      && ptr_ff == PTR_STATUS)
    else $error("device reset left status set");

  // config write clears the reset flag
  a_cfg_clr_rst: assert property (@(posedge core_clk) disable iff (rst)
    accept && cmd.code == CMD_WR_CFG |=> !rst_flag_ff)
    else $error("reset flag not cleared");

  // adjust port points and restarts readback
  a_adj_ptr: assert property (@(posedge core_clk) disable iff (rst)
    accept && cmd.code == CMD_ADJ_PORT |=> ptr_ff == PTR_PORT && pidx_ff == 3'h0)
    else $error("adjust port pointer wrong");

  // port readback wraps after eight reads
  a_port_wrap: assert property (@(posedge core_clk) disable iff (rst)
    ce && rd_byte_strobe && ptr_ff == PTR_PORT && pidx_ff == PORT_LAST && !cmd_valid
    |=> pidx_ff == 3'h0)
    else $error("port readback did not wrap");

  // port bytes carry zero upper nibble
  a_port_upper: assert property (@(posedge core_clk) disable iff (rst)
    ce && rd_byte_strobe && ptr_ff == PTR_PORT |=> rd_data_ff[7:4] == 4'h0)
    else $error("port byte upper nibble set");

  // invalid command answered by refusal, never by both
  a_ack_excl: assert property (@(posedge core_clk) disable iff (rst)
    ce && cmd_valid |=> cmd_ack_ff != cmd_nack_ff)
    else $error("acknowledge and refusal clash");

  // result bits hold without a finishing command or reset
  a_status_quiet: assert property (@(posedge core_clk) disable iff (rst)
    !done_evt && !dev_rst |=> $stable({ppd_ff, sd_ff, sbr_ff, tsb_ff, dir_ff}))
    else $error("status changed without command");

endmodule

`default_nettype wire

// ==== test/bsr_line_model.sv ====
// Purpose: behavioural waveform generator that answers line commands
// Assumes: bench sets the knobs before each command is offered
// Notes: the line rests at idle_lvl between operations, as a pull-up would
`timescale 1ns/10ps
`default_nettype none
module bsr_line_model
  import bsr_pkg::*;
(
  // clocks
  input wire logic core_clk,
  input wire logic link_clk,
  // operation request from the block
  input wire logic ow_start_ff,
  input wire logic [7:0] ow_cmd_ff,
  // knobs: {dir, second, first, presence, short}
  input wire logic [4:0] knob,
  input wire logic [3:0] slow,
  input wire logic idle_lvl,
  // link side
  output logic io_in,
  output logic lk_sample_short,
  output logic lk_sample_presence,
  output logic lk_sample_read,
  output logic lk_dir,
  output logic lk_op_done,
  output logic m_act
);
  integer starts = 0; // starts seen on the core side
  integer seen = 0; // starts already served

  // a start is one core cycle wide, too short to sample on link_clk
  always @(posedge core_clk) begin
    if (ow_start_ff === 1'b1) starts <= starts + 1;
  end

  // drive the line, then give the synchronisers time
  task automatic settle(input logic lvl);
    io_in <= lvl;
    repeat (3 + slow) @(posedge link_clk);
  endtask

  // one link cycle pulse on the chosen strobe
  task automatic pulse(input int k);
    case (k)
      0: lk_sample_short <= 1'b1;
      1: lk_sample_presence <= 1'b1;
      2: lk_sample_read <= 1'b1;
      default: lk_op_done <= 1'b1;
    endcase
    @(posedge link_clk);
    // drop only this strobe, so a following pulse may raise another at once
    case (k)
      0: lk_sample_short <= 1'b0;
      1: lk_sample_presence <= 1'b0;
      2: lk_sample_read <= 1'b0;
      default: lk_op_done <= 1'b0;
    endcase
  endtask

  // serve one operation at a time
  initial begin
    {io_in, lk_sample_short, lk_sample_presence, lk_sample_read, lk_dir, lk_op_done, m_act} = 7'h40;
    forever begin
      @(posedge link_clk);
      if (starts == seen) begin
        // line released: back to the pulled level
        io_in <= idle_lvl;
      end else begin
        seen = starts;
        m_act <= 1'b1;
        if (ow_cmd_ff == CMD_LINE_RESET) begin
          settle(~knob[0]);
          pulse(0);
          settle(~(knob[0] | knob[1]));
          pulse(1);
        end else if (ow_cmd_ff == CMD_SINGLE_BIT || ow_cmd_ff == CMD_TRIPLET) begin
          settle(knob[2]);
          pulse(2);
          if (ow_cmd_ff == CMD_TRIPLET) begin
            settle(knob[3]);
            pulse(2);
            lk_dir <= knob[4];
          end
        end else settle(1'b1);
        pulse(3);
        m_act <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/bsr_status_readback_tb.sv ====
// Purpose: self-checking bench for status and port readback
// Assumes: line model answers every accepted line command
// Notes: random draws come from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module bsr_status_readback_tb
  import bsr_pkg::*;
;
  logic core_clk = 0, link_clk = 0, rst = 1, ce = 1;
  logic cmd_valid = 0, rd_addr_strobe = 0, rd_byte_strobe = 0;
  bsr_cmd_t cmd = '0;
  logic [7:0] ext_rdata = 8'h5a, ext_cfg = 8'h3c, rd_data_ff, ow_cmd_ff, ow_param_ff;
  logic cmd_ack_ff, cmd_nack_ff, ow_start_ff, io_in, m_act;
  logic lk_sample_short, lk_sample_presence, lk_sample_read, lk_dir, lk_op_done;
  logic [4:0] knob = '0; // line answers for the next operation
  logic [3:0] slow = '0; // extra settle cycles in the model
  logic idle_lvl = 1'b1;
  integer seed = 60, err_count = 0, cmp_count = 0;
  logic [3:0] slot [8]; // expected port codes
  logic [7:0] st_x = 8'h10; // expected status byte

  always #5 core_clk = ~core_clk;
  always #16 link_clk = ~link_clk;

  bsr_status_readback dut_u (.core_clk, .rst, .ce, .cmd_valid, .cmd, .cmd_ack_ff, .cmd_nack_ff,
    .rd_addr_strobe, .rd_byte_strobe, .ext_rdata, .ext_cfg, .rd_data_ff, .ow_start_ff, .ow_cmd_ff,
    .ow_param_ff, .io_in, .link_clk, .lk_sample_short, .lk_sample_presence, .lk_sample_read,
    .lk_dir, .lk_op_done);
  bsr_line_model line_u (.core_clk, .link_clk, .ow_start_ff, .ow_cmd_ff, .knob, .slow, .idle_lvl,
    .io_in, .lk_sample_short, .lk_sample_presence, .lk_sample_read, .lk_dir, .lk_op_done, .m_act);

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // offer one command, expect accept or refusal
  task automatic send(input logic [7:0] c, input logic [7:0] p, input logic h, input logic ok);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd <= {c, p, h};
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
    chk("ack", {6'h0, cmd_ack_ff, cmd_nack_ff}, {6'h0, ok, ~ok});
  endtask

  // a=1 is a read-mode addressing, else a byte read
  task automatic rd(input logic a = 1'b0);
    @(posedge core_clk);
    if (a) rd_addr_strobe <= 1'b1;
    else rd_byte_strobe <= 1'b1;
    @(posedge core_clk);
    {rd_addr_strobe, rd_byte_strobe} <= 2'b00;
    #1;
  endtask

  // wait for the line model to take up the operation and then finish it
  task automatic await_model();
    for (int i = 0; i < 20 && m_act !== 1'b1; i++) @(posedge core_clk);
    for (int i = 0; i < 300 && m_act !== 1'b0; i++) @(posedge core_clk);
  endtask

  // status a line command should leave, from the answers given to the model
  function automatic logic [7:0] exp_status(input logic [7:0] st, input logic [1:0] op, input logic [4:0] kb);
    logic [7:0] r;
    r = st;
    if (op == 2'd0) begin
      r[ST_SD] = kb[0];
      r[ST_PPD] = kb[1] & ~kb[0];
    end else if (op == 2'd1) begin
      r[ST_SBR] = kb[2];
    end else if (op == 2'd2) begin
      r[ST_DIR] = kb[4];
      r[ST_TSB] = kb[3];
      r[ST_SBR] = kb[2];
    end
    return r;
  endfunction

  // run a line command to completion and check the status it leaves
  task automatic line(input logic [7:0] c, input logic [7:0] p, input logic [7:0] nx);
    send(c, p, c != CMD_LINE_RESET && c != CMD_READ_BYTE, 1'b1);
    chk("op start", {7'h00, ow_start_ff}, 8'h01);
    chk("op code", ow_cmd_ff, c);
    chk("op param", ow_param_ff, p);
    rd();
    chk("busy", rd_data_ff, st_x | 8'h01);
    send(CMD_SINGLE_BIT, 8'h00, 1'b1, 1'b0);
    chk("no start", {7'h00, ow_start_ff}, 8'h00);
    await_model();
    for (int i = 0; i < 20 && rd_data_ff[ST_BUSY] !== 1'b0; i++) rd();
    st_x = nx;
    chk("status", rd_data_ff, st_x);
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog, well beyond the expected run
  initial begin
    #400000;
    err_count++;
    conclude();
  end

  initial begin
    logic [7:0] nx, p;
    logic [1:0] op;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    rd();
    chk("reset", rd_data_ff, st_x);
    // level follows the line only with the pointer at status
    rd(1'b1);
    rd();
    st_x[ST_LL] = 1'b1;
    chk("level", rd_data_ff, st_x);
    send(CMD_SET_PTR, PTR_PORT, 1'b1, 1'b1);
    idle_lvl = 1'b0;
    repeat (4) @(posedge core_clk);
    rd(1'b1);
    send(CMD_SET_PTR, PTR_STATUS, 1'b1, 1'b1);
    rd();
    chk("level kept", rd_data_ff, st_x);
    rd(1'b1);
    rd();
    st_x[ST_LL] = 1'b0;
    chk("level low", rd_data_ff, st_x);
    idle_lvl = 1'b1;
    // other pointers and refusals
    ext_rdata <= 8'($random(seed));
    send(CMD_SET_PTR, PTR_RDATA, 1'b1, 1'b1);
    rd();
    chk("rdata", rd_data_ff, ext_rdata);
    send(CMD_SET_PTR, PTR_CFG, 1'b1, 1'b1);
    rd();
    chk("cfg", rd_data_ff, {4'h0, ext_cfg[3:0]});
    send(CMD_SET_PTR, 8'h55, 1'b1, 1'b0);
    send(CMD_SET_PTR, PTR_STATUS, 1'b0, 1'b0);
    send(8'h00, 8'h00, 1'b0, 1'b0);
    // line commands: reset corners first, then random mix
    for (int i = 0; i < 14; i++) begin
      knob = 5'($random(seed));
      slow = 4'($random(seed) & 3);
      op = (i < 4) ? 2'd0 : 2'($random(seed));
      if (i < 4) knob[1:0] = 2'(i);
      nx = exp_status(st_x, op, knob);
      case (op)
        2'd0: line(CMD_LINE_RESET, 8'h00, nx);
        2'd1: line(CMD_SINGLE_BIT, {knob[2], 7'h00}, nx);
        2'd2: line(CMD_TRIPLET, 8'h00, nx);
        default: line(knob[4] ? CMD_WRITE_BYTE : CMD_READ_BYTE, 8'h3c, nx);
      endcase
    end
    // config write clears the reset flag only with a valid byte
    send(CMD_WR_CFG, 8'h11, 1'b1, 1'b0);
    send(CMD_WR_CFG, 8'h1e, 1'b1, 1'b1);
    send(CMD_SET_PTR, PTR_STATUS, 1'b1, 1'b1);
    rd();
    st_x[ST_RST] = 1'b0;
    chk("flag clear", rd_data_ff, st_x);
    // device reset in mid-operation
    slow = 4'h3;
    send(CMD_LINE_RESET, 8'h00, 1'b0, 1'b1);
    send(CMD_DEV_RESET, 8'h00, 1'b0, 1'b1);
    st_x = 8'h10 | (st_x & 8'h08);
    rd();
    chk("dev reset", rd_data_ff, st_x);
    await_model();
    repeat (6) @(posedge core_clk);
    rd();
    chk("late done", rd_data_ff, st_x);
    // port readback: fill every slot, read past the wrap
    for (int j = 0; j < 8; j++) begin
      p = {(j < 6) ? 3'(j / 2) : 3'(j - 3), (j < 6) ? 1'(j % 2) : 1'($random(seed)), 4'($random(seed))};
      slot[j] = p[3:0];
      send(CMD_ADJ_PORT, p, 1'b1, 1'b1);
    end
    for (int k = 0; k < 19; k++) begin
      rd();
      chk("port", rd_data_ff, {4'h0, slot[k % 8]});
    end
    send(CMD_ADJ_PORT, 8'ha0, 1'b1, 1'b0);
    rd();
    chk("port next", rd_data_ff, {4'h0, slot[3]});
    send(CMD_SET_PTR, PTR_PORT, 1'b1, 1'b1);
    rd();
    chk("port restart", rd_data_ff, {4'h0, slot[0]});
    // clock enable low: a read strobe must neither load nor advance
    @(posedge core_clk);
    ce <= 1'b0;
    rd();
    chk("frozen", rd_data_ff, {4'h0, slot[0]});
    @(posedge core_clk);
    ce <= 1'b1;
    rd();
    chk("thawed", rd_data_ff, {4'h0, slot[1]});
    conclude();
  end
endmodule
`default_nettype wire
